/* include/cfr_pkg.sv */
/*
 * Shared constants and carrier types for the CPU flag register block:
 * register offsets, flag bit positions, reset values and timing counts.
 * Assumes a 16-bit flag word and a 32-bit Avalon-MM register bus.
 */
package cfr_pkg;

    // flag word layout
    localparam int unsigned FLAG_W       = 16;
    localparam int unsigned BIT_CARRY    = 0;
    localparam int unsigned BIT_DEBUG    = 1;
    localparam int unsigned BIT_ZERO     = 2;
    localparam int unsigned BIT_SIGN     = 3;
    localparam int unsigned BIT_BANK     = 4;
    localparam int unsigned BIT_OVF      = 5;
    localparam int unsigned BIT_IEN      = 6;
    localparam int unsigned BIT_STACK    = 7;
    localparam int unsigned IPL_LO       = 12;
    localparam int unsigned IPL_W        = 3;
    localparam logic [15:0] FLAGS_RESET  = 16'h0000;
    localparam logic [15:0] FLAGS_MASK   = 16'h70FF;

    // register byte offsets and ctrl/status bit positions
    localparam logic [3:0]  OFS_FLAGS    = 4'h0;
    localparam logic [3:0]  OFS_CTRL     = 4'h4;
    localparam logic [3:0]  OFS_STATUS   = 4'h8;
    localparam int unsigned CTRL_SWRST   = 0;
    localparam int unsigned ST_BANK      = 0;
    localparam int unsigned ST_STACK     = 1;
    localparam int unsigned ST_STEP      = 2;
    localparam int unsigned ST_RUN       = 3;

    // timing and vector limits
    localparam int unsigned MIN_RST_CYCLES = 20;
    localparam logic [5:0]  SWINT_SPLIT    = 6'h20;
    localparam int unsigned VEC_W          = 20;

    typedef struct packed {
        logic        upd_c;
        logic        upd_z;
        logic        upd_s;
        logic        upd_o;
        logic        carry;
        logic        ovf;
        logic [15:0] result;
    } cfr_alu_t;

    typedef struct packed {
        logic       req;
        logic [2:0] prio;
        logic       maskable;
    } cfr_irq_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] num;
    } cfr_swint_t;

endpackage : cfr_pkg

/* design/cfr_port_gate.sv */
/*
 * Output gate for a group of general-purpose port pins.
 * Assumes core_rst is high for every kind of reset; pins then float.
 */
`timescale 1ns/100ps
module cfr_port_gate #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             core_rst,
    input  wire logic [WIDTH-1:0] oe_req,
    input  wire logic [WIDTH-1:0] out_req,
    output logic      [WIDTH-1:0] port_oe,
    output logic      [WIDTH-1:0] port_out
);
    if (WIDTH < 1) begin : g_chk
        $error("cfr_port_gate: WIDTH must be at least 1");
    end

    // pins are inputs while any reset is held
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_oe  <= '0;
            port_out <= '0;
        end else if (ce) begin
            port_oe  <= core_rst ? '0 : oe_req;
            port_out <= core_rst ? '0 : out_req;
        end
    end

    a_port_float: assert property (@(posedge clk) disable iff (!nrst)
        core_rst && ce |=> port_oe == '0)
        else $error("port driven during reset");

endmodule : cfr_port_gate

/* design/cfr_reset_ctl.sv */
/*
 * Reset sequencer: holds the core in reset after the pin or a software
 * request, waits for a stable main clock, then pulses fetch_start.
 * Assumes clk_stable is synchronous to clk.
 */
`timescale 1ns/100ps
module cfr_reset_ctl #(
    parameter int unsigned HOLD_CYCLES = cfr_pkg::MIN_RST_CYCLES
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic sw_reset_req,
    input  wire logic clk_stable,
    output logic      core_rst,
    output logic      fetch_start,
    output logic      running
);
    import cfr_pkg::*;

    localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

    if (HOLD_CYCLES < 1) begin : g_chk
        $error("cfr_reset_ctl: HOLD_CYCLES must be at least 1");
    end

    typedef enum logic [1:0] {RST_SW_HOLD, RST_WAIT_CLK, RST_RUN} cfr_rst_state_t;

    cfr_rst_state_t   state;
    logic [CNT_W-1:0] hold_cnt;

    // software reset mimics the pin's minimum hold time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state       <= RST_WAIT_CLK;
            hold_cnt    <= '0;
            core_rst    <= 1'b1;
            fetch_start <= 1'b0;
            running     <= 1'b0;
        end else if (ce) begin
            fetch_start <= 1'b0;
            unique case (state)
                RST_SW_HOLD: begin
                    if (hold_cnt == CNT_W'(HOLD_CYCLES - 1)) begin
                        state <= RST_WAIT_CLK;
                    end
                    hold_cnt <= hold_cnt + 1'b1;
                end
                RST_WAIT_CLK: begin
                    if (clk_stable) begin
                        state       <= RST_RUN;
                        core_rst    <= 1'b0;
                        fetch_start <= 1'b1;
                        running     <= 1'b1;
                    end
                end
                RST_RUN: begin
                    if (sw_reset_req) begin
                        state    <= RST_SW_HOLD;
                        hold_cnt <= '0;
                        core_rst <= 1'b1;
                        running  <= 1'b0;
                    end
                end
            endcase
        end
    end

    a_fetch_stable: assert property (@(posedge clk) disable iff (!nrst)
        $rose(fetch_start) |-> $past(clk_stable) && !core_rst)
        else $error("fetch started without stable clock");

    a_sw_hold_len: assert property (@(posedge clk) disable iff (!nrst)
        $rose(core_rst) |-> core_rst [*8])
        else $error("software reset released too early");

endmodule : cfr_reset_ctl

/* design/cfr_flags.sv */
/*
 * Processor status flag word with interrupt gating and reset entry.
 * Holds carry, debug, zero, sign, bank, overflow, interrupt enable,
 * stack select and the priority level; gates interrupt acceptance;
 * sequences reset and floats the port pins. Registers sit on an
 * Avalon-MM slave with waitrequest. Assumes one clock, synchronous
 * inputs, and an ALU that presents its result with update strobes.
 */

// Contract
// - Bit 0 takes the ALU carry, borrow or shifted-out bit.
// - With bit 1 set a single-step interrupt follows each instruction; the ack clears it.
// - Bit 2 is one for a zero ALU result and zero otherwise.
// - Bit 3 is one for a negative ALU result and zero otherwise.
// - Bit 4 selects register bank zero or one.
// - Bit 5 is one on ALU overflow and zero otherwise.
// - Bit 6 gates maskable interrupts and is cleared when one is acknowledged.
// - Bit 7 selects the interrupt stack pointer at zero and the user stack pointer at one.
// - Bit 7 clears on a hardware interrupt or a software interrupt numbered 0 to 31.
// - Bits 8 to 11 and bit 15 are reserved and read as zero.
// - Bits 12 to 14 hold the priority level from 0 to 7.
// - An interrupt is taken only if its priority exceeds the priority level.
// - After reset, with a stable clock, fetching starts at the reset vector.
// - Pin reset and software reset leave the same state behind.
// - Port pins float while reset is held.
`timescale 1ns/100ps
module cfr_flags #(
    parameter int unsigned PORT_W     = 8,
    parameter int unsigned RST_HOLD   = cfr_pkg::MIN_RST_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    // avalon-mm slave
    input  wire logic [3:0]                  address,
    input  wire logic                        read,
    input  wire logic                        write,
    input  wire logic [31:0]                 writedata,
    input  wire logic [3:0]                  byteenable,
    output logic      [31:0]                 readdata,
    output logic                             waitrequest,
    // core side
    input  wire logic                        clk_stable,
    input  wire logic [cfr_pkg::VEC_W-1:0]   reset_vector,
    input  wire cfr_pkg::cfr_alu_t           alu,
    input  wire logic                        flag_wr,
    input  wire logic [15:0]                 flag_wdata,
    input  wire logic                        instr_done,
    input  wire cfr_pkg::cfr_irq_t           irq,
    input  wire logic                        step_ack,
    input  wire cfr_pkg::cfr_swint_t         swint,
    output logic                             irq_accept,
    output logic                             step_irq,
    output logic [15:0]                      flags,
    output logic                             bank_sel,
    output logic                             stack_sel,
    output logic [2:0]                       cpu_priority_level,
    output logic                             core_rst,
    output logic                             fetch_start,
    output logic [cfr_pkg::VEC_W-1:0]        fetch_addr,
    // port pins
    input  wire logic [PORT_W-1:0]           port_oe_req,
    input  wire logic [PORT_W-1:0]           port_out_req,
    output logic      [PORT_W-1:0]           port_oe,
    output logic      [PORT_W-1:0]           port_out
);
    import cfr_pkg::*;

    if (PORT_W < 1 || RST_HOLD < MIN_RST_CYCLES) begin : g_chk
        $error("cfr_flags: PORT_W or RST_HOLD out of range");
    end

    logic [15:0] next_flags;
    logic [15:0] bus_mask;
    logic        bus_done;
    logic        bus_flag_wr;
    logic        accept_now;
    logic        swint_low;
    logic        sw_reset_req;
    logic        running;
    logic        next_step;

    // reset sequencing and pin floating
    cfr_reset_ctl #(
        .HOLD_CYCLES (RST_HOLD)
    ) u_rst (
        .clk          (clk),
        .nrst         (nrst),
        .ce           (ce),
        .sw_reset_req (sw_reset_req),
        .clk_stable   (clk_stable),
        .core_rst     (core_rst),
        .fetch_start  (fetch_start),
        .running      (running)
    );

    cfr_port_gate #(
        .WIDTH (PORT_W)
    ) u_ports (
        .clk      (clk),
        .nrst     (nrst),
        .ce       (ce),
        .core_rst (core_rst),
        .oe_req   (port_oe_req),
        .out_req  (port_out_req),
        .port_oe  (port_oe),
        .port_out (port_out)
    );

    // bus handshake: one wait cycle, then the transfer completes
    assign bus_done    = (read || write) && !waitrequest;
    assign bus_flag_wr = write && bus_done && address == OFS_FLAGS;
    assign bus_mask    = {{8{byteenable[1]}}, {8{byteenable[0]}}};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
        end else if (ce) begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    // read data registered in the wait cycle so it stands with the answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (ce && read && waitrequest) begin
            unique case (address)
                OFS_FLAGS:  readdata <= {16'h0000, flags};
                OFS_STATUS: readdata <= {28'h000_0000, running, step_irq,
                                         stack_sel, bank_sel};
                default:    readdata <= 32'h0000_0000; // ctrl and unmapped
            endcase
        end
    end

    // software reset request, a one-cycle pulse into the sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw_reset_req <= 1'b0;
        end else if (ce) begin
            sw_reset_req <= write && bus_done && address == OFS_CTRL
                            && byteenable[0] && writedata[CTRL_SWRST];
        end
    end

    // interrupt gate; a pending single step outranks a new request
    assign accept_now = irq.req && !core_rst && !step_irq
                        && irq.prio > flags[IPL_LO +: IPL_W]
                        && (!irq.maskable || flags[BIT_IEN]);
    assign swint_low  = swint.valid && swint.num < SWINT_SPLIT;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_accept <= 1'b0;
        end else if (ce) begin
            irq_accept <= accept_now;
        end
    end

    // single step: the set wins over an acknowledge in the same cycle
    always_comb begin
        next_step = step_irq;
        if (step_ack) begin
            next_step = 1'b0;
        end
        if (instr_done && flags[BIT_DEBUG]) begin
            next_step = 1'b1;
        end
        if (core_rst) begin
            next_step = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_irq <= 1'b0;
        end else if (ce) begin
            step_irq <= next_step;
        end
    end

    // flag word: writes first, then alu results, then interrupt clears
    always_comb begin
        next_flags = flags;
        if (flag_wr) begin
            next_flags = flag_wdata;
        end else if (bus_flag_wr) begin
            next_flags = (flags & ~bus_mask) | (writedata[15:0] & bus_mask);
        end
        if (alu.upd_c) begin
            next_flags[BIT_CARRY] = alu.carry;
        end
        if (alu.upd_z) begin
            next_flags[BIT_ZERO] = alu.result == 16'h0000;
        end
        if (alu.upd_s) begin
            next_flags[BIT_SIGN] = alu.result[FLAG_W-1];
        end
        if (alu.upd_o) begin
            next_flags[BIT_OVF] = alu.ovf;
        end
        if (swint_low) begin
            next_flags[BIT_STACK] = 1'b0;
        end
        if (accept_now) begin
            next_flags[BIT_IEN]   = 1'b0;
            next_flags[BIT_STACK] = 1'b0;
        end
        if (step_ack) begin
            next_flags[BIT_DEBUG] = 1'b0;
            next_flags[BIT_IEN]   = 1'b0;
            next_flags[BIT_STACK] = 1'b0;
        end
        next_flags = next_flags & FLAGS_MASK;
        if (core_rst) begin
            next_flags = FLAGS_RESET;
        end
    end

    // same clear for pin and software reset, so both end alike
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags <= FLAGS_RESET;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    // selects are plain flag bits, so they switch with the word
    assign bank_sel           = flags[BIT_BANK];
    assign stack_sel          = flags[BIT_STACK];
    assign cpu_priority_level = flags[IPL_LO +: IPL_W];

    // vector sampled throughout reset, stable by the fetch pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fetch_addr <= '0;
        end else if (ce && core_rst) begin
            fetch_addr <= reset_vector;
        end
    end

    // flag update checks
    a_carry_take: assert property (@(posedge clk) disable iff (!nrst)
        ce && !core_rst && alu.upd_c |=> flags[BIT_CARRY] == $past(alu.carry))
        else $error("carry flag not taken from alu");

    a_zero_flag: assert property (@(posedge clk) disable iff (!nrst)
        ce && !core_rst && alu.upd_z
        |=> flags[BIT_ZERO] == ($past(alu.result) == 16'h0000))
        else $error("zero flag wrong");

    a_sign_flag: assert property (@(posedge clk) disable iff (!nrst)
        ce && !core_rst && alu.upd_s
        |=> flags[BIT_SIGN] == $past(alu.result[15]))
        else $error("sign flag wrong");

    a_ovf_flag: assert property (@(posedge clk) disable iff (!nrst)
        ce && !core_rst && alu.upd_o |=> flags[BIT_OVF] == $past(alu.ovf))
        else $error("overflow flag wrong");

    a_step_raise: assert property (@(posedge clk) disable iff (!nrst)
        ce && !core_rst && instr_done && flags[BIT_DEBUG] |=> step_irq)
        else $error("single step not raised");

    a_step_ack: assert property (@(posedge clk) disable iff (!nrst)
        ce && step_ack |=> !flags[BIT_DEBUG] && !flags[BIT_IEN])
        else $error("debug flag kept after acknowledge");

    // interrupt gate and reserved bit checks
    a_prio_block: assert property (@(posedge clk) disable iff (!nrst)
        ce && irq.prio <= flags[IPL_LO +: IPL_W] |=> !irq_accept)
        else $error("interrupt taken at or below level");

    a_mask_block: assert property (@(posedge clk) disable iff (!nrst)
        ce && irq.maskable && !flags[BIT_IEN] |=> !irq_accept)
        else $error("masked interrupt taken");

    a_accept_clear: assert property (@(posedge clk) disable iff (!nrst)
        $rose(irq_accept) |-> !flags[BIT_IEN] && !stack_sel)
        else $error("accept left enable or user stack");

    a_swint_stack: assert property (@(posedge clk) disable iff (!nrst)
        ce && !core_rst && swint_low |=> !stack_sel)
        else $error("low software interrupt kept user stack");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        ce && flag_wr ##1 1'b1 |-> (flags & ~FLAGS_MASK) == 16'h0000)
        else $error("reserved flag bits set");

    // reset, vector and bus checks
    a_reset_clean: assert property (@(posedge clk) disable iff (!nrst)
        ce && core_rst |=> flags == FLAGS_RESET && !step_irq)
        else $error("reset left flags set");

    a_fetch_vector: assert property (@(posedge clk) disable iff (!nrst)
        $rose(fetch_start) |-> fetch_addr == $past(reset_vector))
        else $error("fetch address not the reset vector");

    a_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
        ce && (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle late");

    // level and bank move only by a write or a reset
    a_level_hold: assert property (@(posedge clk) disable iff (!nrst)
        ce && !core_rst && !flag_wr && !bus_flag_wr
        |=> $stable(flags[IPL_LO +: IPL_W]))
        else $error("priority level changed without a write");

    a_bank_hold: assert property (@(posedge clk) disable iff (!nrst)
        ce && !core_rst && !flag_wr && !bus_flag_wr
        |=> $stable(bank_sel))
        else $error("bank select changed without a write");

    a_accept_legal: assert property (@(posedge clk) disable iff (!nrst)
        $past(ce) && irq_accept
        |-> $past(irq.req) && $past(irq.prio) > $past(flags[IPL_LO +: IPL_W]))
        else $error("interrupt taken without higher priority");

    a_step_block: assert property (@(posedge clk) disable iff (!nrst)
        ce && step_irq |=> !irq_accept)
        else $error("interrupt taken over pending single step");

    a_freeze_flags: assert property (@(posedge clk) disable iff (!nrst)
        !ce |=> $stable(flags) && $stable(irq_accept))
        else $error("state moved with clock enable low");

    a_port_quiet: assert property (@(posedge clk) disable iff (!nrst)
        ce && core_rst |=> port_out == '0)
        else $error("port output value driven during reset");

    // main scenarios worth seeing reached
    c_irq_taken: cover property (@(posedge clk) disable iff (!nrst) $rose(irq_accept));
    c_step_done: cover property (@(posedge clk) disable iff (!nrst) step_irq ##1 !step_irq);
    c_sw_reset:  cover property (@(posedge clk) disable iff (!nrst) sw_reset_req ##[1:60] fetch_start);
    c_swint_low: cover property (@(posedge clk) disable iff (!nrst) stack_sel && swint_low);
    c_ce_freeze: cover property (@(posedge clk) disable iff (!nrst) !ce ##1 ce);

endmodule : cfr_flags

/* testbench/cfr_flags_bench.sv */
/*
 * Self-checking bench for the cpu flag register block: bus tasks and
 * sequences for flags, interrupts, single step and both resets.
 * Assumes the design carries its own assertions; one 100 MHz clock.
 */
`timescale 1ns/100ps
module cfr_flags_bench;
    import cfr_pkg::*;
    localparam int unsigned HOLD = 20;
    logic              clk;
    logic              nrst;
    logic [3:0]        address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic              clk_stable;
    logic              ce;
    logic              flag_wr;
    logic [15:0]       flag_wdata;
    cfr_alu_t          alu;
    logic              instr_done;
    cfr_irq_t          irq;
    logic              step_ack;
    cfr_swint_t        swint;
    logic              irq_accept, step_irq, bank_sel, stack_sel, core_rst, fetch_start;
    logic [15:0]       flags;
    logic [2:0]        cpu_priority_level;
    logic [VEC_W-1:0]  fetch_addr;
    logic [7:0]        oe_req, port_oe, port_out;
    logic [31:0]       q;
    logic              acc;
    int                n, cycles, mismatches, n_tests;

    cfr_flags #(.PORT_W(8), .RST_HOLD(HOLD)) dut (
        .clk, .nrst, .ce, .address, .read, .write, .writedata,
        .byteenable(4'hF), .readdata, .waitrequest, .clk_stable,
        .reset_vector(20'hABCDE), .alu, .flag_wr, .flag_wdata,
        .instr_done, .irq, .step_ack, .swint, .irq_accept, .step_irq, .flags,
        .bank_sel, .stack_sel, .cpu_priority_level, .core_rst, .fetch_start,
        .fetch_addr, .port_oe_req(oe_req), .port_out_req(8'hA5), .port_oe, .port_out
    );

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard, far above the hundred-odd cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // one avalon transfer; trailing edge keeps back-to-back calls apart
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(what, exp, q);
    endtask : rd_chk

    // drive one alu result with every update strobe set
    task automatic alu_op(input logic c, input logic o, input logic [15:0] r);
        alu <= {4'hF, c, o, r};
        @(posedge clk);
        alu <= '0;
        repeat (2) @(posedge clk);
    endtask : alu_op

    // hold a request three cycles and note any acceptance
    task automatic irq_try(input logic [2:0] p, input logic m);
        acc = 1'b0;
        irq <= '{1'b1, p, m};
        repeat (3) begin
            @(posedge clk);
            if (irq_accept === 1'b1) acc = 1'b1;
        end
        irq <= '{1'b0, 3'h0, 1'b0};
        @(posedge clk);
    endtask : irq_try

    task automatic swi(input logic [5:0] num);
        swint <= '{1'b1, num};
        @(posedge clk);
        swint <= '{1'b0, 6'h00};
        repeat (2) @(posedge clk);
    endtask : swi

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        nrst = 1'b0;
        clk_stable = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        alu = '0;
        instr_done = 1'b0;
        irq = '0;
        step_ack = 1'b0;
        swint = '0;
        oe_req = 8'hFF;
        ce = 1'b1;
        flag_wr = 1'b0;
        flag_wdata = 16'h0000;
        repeat (HOLD) @(posedge clk);
        chk("port_oe in reset", 32'h0, port_oe);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        chk("core_rst before stable", 32'h1, core_rst);
        clk_stable <= 1'b1;
        do @(posedge clk); while (fetch_start !== 1'b1);
        chk("fetch_addr", 32'h000ABCDE, fetch_addr);
        chk("core_rst at fetch", 32'h0, core_rst);
        rd_chk("flags after reset", OFS_FLAGS, 32'h00000000);
        chk("port_out", 32'hA5, port_out);
        chk("port_oe running", 32'hFF, port_oe);
        rd_chk("unmapped read", 4'hC, 32'h00000000);
        $display("test reset entry done");

        alu_op(1'b1, 1'b1, 16'h0000);
        chk("carry zero ovf", 32'h0025, flags);
        alu_op(1'b0, 1'b0, 16'h8000);
        chk("sign", 32'h0008, flags);
        alu_op(1'b0, 1'b0, 16'h0001);
        chk("positive result", 32'h0000, flags);
        $display("test alu flags done");

        bus(1'b1, OFS_FLAGS, 32'hFFFFFFFF);
        rd_chk("reserved bits", OFS_FLAGS, 32'h000070FF);
        chk("bank_sel", 32'h1, bank_sel);
        chk("stack_sel", 32'h1, stack_sel);
        chk("priority level", 32'h7, cpu_priority_level);
        bus(1'b1, 4'hC, 32'h00000000);
        rd_chk("after unmapped write", OFS_FLAGS, 32'h000070FF);
        $display("test flag word done");

        // core load masks reserved bits; a low clock enable freezes the word
        flag_wdata <= 16'h8F0A;
        flag_wr <= 1'b1;
        @(posedge clk);
        flag_wr <= 1'b0;
        @(posedge clk);
        chk("core flag load", 32'h0000000A, flags);
        ce <= 1'b0;
        alu <= {4'hF, 1'b1, 1'b1, 16'h8000};
        repeat (2) @(posedge clk);
        alu <= '0;
        ce <= 1'b1;
        @(posedge clk);
        chk("flags frozen", 32'h0000000A, flags);
        $display("test core load and freeze done");

        bus(1'b1, OFS_FLAGS, 32'h000030C0);
        irq_try(3'h3, 1'b1);
        chk("equal priority taken", 32'h0, acc);
        irq_try(3'h4, 1'b1);
        chk("higher priority taken", 32'h1, acc);
        chk("flags after accept", 32'h3000, flags);
        irq_try(3'h7, 1'b1);
        chk("masked taken", 32'h0, acc);
        $display("test interrupt gating done");

        bus(1'b1, OFS_FLAGS, 32'h00000080);
        swi(6'h1F);
        chk("swint 31 stack", 32'h0, stack_sel);
        bus(1'b1, OFS_FLAGS, 32'h00000080);
        swi(6'h20);
        chk("swint 32 stack", 32'h1, stack_sel);
        $display("test software interrupt done");

        bus(1'b1, OFS_FLAGS, 32'h00000002);
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        repeat (2) @(posedge clk);
        chk("step_irq", 32'h1, step_irq);
        step_ack <= 1'b1;
        @(posedge clk);
        step_ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk("debug after ack", 32'h0, flags);
        chk("step_irq after ack", 32'h0, step_irq);
        $display("test single step done");

        // software reset must land on the same state as the pin
        bus(1'b1, OFS_FLAGS, 32'h000070F5);
        bus(1'b1, OFS_CTRL, 32'h00000001);
        n = 0;
        while (core_rst !== 1'b1) @(posedge clk);
        while (core_rst === 1'b1) begin
            @(posedge clk);
            n++;
            if (n == 3) chk("port_oe in sw reset", 32'h0, port_oe);
            if (n == 3) chk("port_out in sw reset", 32'h0, port_out);
        end
        chk("sw reset hold", 32'h1, n >= HOLD);
        rd_chk("flags after sw reset", OFS_FLAGS, 32'h00000000);
        rd_chk("status after sw reset", OFS_STATUS, 32'h00000008);
        $display("test software reset done");
        stop_test();
    end
endmodule : cfr_flags_bench
